// ===== tpc_pkg.sv
`default_nettype none
// ============================================================
// constants and types of the timer prescaler front end
package tpc_pkg;

  // ============================================================
  // register map
  localparam int          TPC_ADDR_W        = 8;
  localparam int          TPC_DATA_W        = 32;
  localparam logic [7:0]  TPC_CTRL_OFS      = 8'h20;
  localparam logic [7:0]  TPC_SEL_OFS       = 8'h24;
  localparam logic [7:0]  TPC_STAT_OFS      = 8'h28;
  localparam logic [7:0]  TPC_CTRL_RESET    = 8'h00;
  localparam logic [11:0] TPC_SEL_RESET     = 12'h000;

  // ============================================================
  // field positions
  localparam int          TPC_HOLD_BIT      = 7;
  localparam int          TPC_OTHER_BIT     = 1;
  localparam int          TPC_SHARED_BIT    = 0;
  localparam int          TPC_SEL_STRIDE    = 4;
  localparam int          TPC_STAT_PIN_LSB  = 16;

  // ============================================================
  // prescaler shape
  localparam int          TPC_NUM_TIMERS    = 3;
  localparam int          TPC_SEL_W         = 3;
  localparam int          TPC_PRESC_W       = 10;
  localparam int          TPC_NUM_TAPS      = 4;
  localparam logic [9:0]  TPC_TAP_MASK [4]  = '{10'h007, 10'h03f, 10'h0ff, 10'h3ff};

  // ============================================================
  // bus answers
  localparam logic [1:0]  TPC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  TPC_RESP_SLVERR   = 2'b10;

  // ============================================================
  // tick source codes
  typedef enum logic [2:0] {
    TPC_SRC_OFF      = 3'h0,
    TPC_SRC_SYS      = 3'h1,
    TPC_SRC_DIV8     = 3'h2,
    TPC_SRC_DIV64    = 3'h3,
    TPC_SRC_DIV256   = 3'h4,
    TPC_SRC_DIV1024  = 3'h5,
    TPC_SRC_EXT_FALL = 3'h6,
    TPC_SRC_EXT_RISE = 3'h7
  } tpc_src_type;

  // control register content
  typedef struct packed {
    logic hold;
    logic other_reset;
    logic shared_reset;
  } tpc_ctrl_type;

endpackage : tpc_pkg
`default_nettype wire

// ===== tpc_pin_edge.sv
`default_nettype none
// ============================================================
// count pin synchroniser and edge detector
module tpc_pin_edge
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // pin
  input  wire logic pin,
  // results
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // RULE6: sampled every clock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // RULE7: one pulse per edge
  assign level = sync2_reg;
  assign rise  = sync2_reg & ~prev_reg;
  assign fall  = ~sync2_reg & prev_reg;

endmodule : tpc_pin_edge
`default_nettype wire

// ===== tpc_tick_select.sv
`default_nettype none
// ============================================================
// per timer tick source selection
module tpc_tick_select
(
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  // selection
  input  wire logic [tpc_pkg::TPC_SEL_W-1:0]   clock_source_select,
  // sources
  input  wire logic [tpc_pkg::TPC_NUM_TAPS-1:0] taps,
  input  wire logic                            ext_rise,
  input  wire logic                            ext_fall,
  // tick
  output logic                                 timer_tick
);

  tpc_pkg::tpc_src_type src;
  logic                 tick_next;

  assign src = tpc_pkg::tpc_src_type'(clock_source_select);

  always_comb
  begin
    tick_next = 1'b0;
    case (src)
      // RULE15: no source, timer stops
      tpc_pkg::TPC_SRC_OFF:      tick_next = 1'b0;
      // RULE1: undivided clock
      tpc_pkg::TPC_SRC_SYS:      tick_next = 1'b1;
      // RULE16: tap order by code
      tpc_pkg::TPC_SRC_DIV8:     tick_next = taps[0];
      tpc_pkg::TPC_SRC_DIV64:    tick_next = taps[1];
      tpc_pkg::TPC_SRC_DIV256:   tick_next = taps[2];
      tpc_pkg::TPC_SRC_DIV1024:  tick_next = taps[3];
      // RULE11: edges never divided
      tpc_pkg::TPC_SRC_EXT_FALL: tick_next = ext_fall;
      tpc_pkg::TPC_SRC_EXT_RISE: tick_next = ext_rise;
      default:                   tick_next = 1'b0;
    endcase
  end

  // registered so every source sees the same one cycle delay
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_tick <= 1'b0;
    else
      timer_tick <= tick_next;
  end

endmodule : tpc_tick_select
`default_nettype wire

// ===== tpc_prescaler_top.sv
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none
// Operation
// RULE1: select code 1 ticks the timer on every system clock.
// RULE2: prescaler offers divide by 8, 64, 256 and 1024 taps.
// RULE3: prescaler runs freely and serves all three timers.
// RULE4: first prescaled tick arrives 1 to N+1 clocks after enabling.
// RULE5: a prescaler reset restarts the period for every connected timer.
// RULE6: count pin is sampled once per clock through synchroniser flops.
// RULE7: one tick per rising edge on code 7, falling edge on 6.
// RULE8: counter updates a few clocks after a pin edge.
// RULE9: software changes the external source only while the pin is stable.
// RULE10: external clock half periods exceed one system clock.
// RULE11: external ticks bypass the prescaler, never divided.
// RULE12: while hold is one, prescaler reset bits keep their written values.
// RULE13: writing hold to zero clears both reset bits by hardware.
// RULE14: shared reset bit resets prescaler, self clears unless hold set.
// RULE15: select code 0 stops the timer.
// RULE16: codes 2 to 5 choose the 8, 64, 256, 1024 taps.
// ============================================================
// prescaler and clock select for three timers, axi4-lite slave
module tpc_prescaler_top
#(
  parameter int NUM_TIMERS = tpc_pkg::TPC_NUM_TIMERS,
  parameter int PRESC_W    = tpc_pkg::TPC_PRESC_W
)
(
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  // axi4-lite write address
  input  wire logic [tpc_pkg::TPC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  // axi4-lite write data
  input  wire logic [tpc_pkg::TPC_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  // axi4-lite read address
  input  wire logic [tpc_pkg::TPC_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  // axi4-lite read data
  output logic [tpc_pkg::TPC_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  // count pins
  input  wire logic [NUM_TIMERS-1:0]           external_count_pin,
  // timer side
  output logic [NUM_TIMERS-1:0]                timer_tick,
  output logic                                 shared_prescaler_reset,
  output logic                                 other_prescaler_reset
);

  // ============================================================
  // declarations
  localparam int SELS_W = NUM_TIMERS * tpc_pkg::TPC_SEL_STRIDE;

  tpc_pkg::tpc_ctrl_type                ctrl_reg;
  tpc_pkg::tpc_ctrl_type                ctrl_next;
  logic [SELS_W-1:0]                    sel_reg;
  logic [PRESC_W-1:0]                   presc_reg;
  logic [tpc_pkg::TPC_NUM_TAPS-1:0]     taps;
  logic [NUM_TIMERS-1:0]                pin_level;
  logic [NUM_TIMERS-1:0]                pin_rise;
  logic [NUM_TIMERS-1:0]                pin_fall;

  logic                                 aw_full_reg;
  logic [tpc_pkg::TPC_ADDR_W-1:0]       aw_addr_reg;
  logic                                 w_full_reg;
  logic [tpc_pkg::TPC_DATA_W-1:0]       w_data_reg;
  logic [3:0]                           w_strb_reg;
  logic                                 bvalid_reg;
  logic [1:0]                           bresp_reg;
  logic                                 rvalid_reg;
  logic [1:0]                           rresp_reg;
  logic [tpc_pkg::TPC_DATA_W-1:0]       rdata_reg;

  logic                                 do_write;
  logic                                 wr_ctrl;
  logic                                 wr_sel;
  logic                                 wr_hit;
  logic                                 rd_take;
  logic                                 rd_hit;
  logic [tpc_pkg::TPC_DATA_W-1:0]       rd_value;
  logic                                 aw_is_ctrl;
  logic                                 aw_is_sel;
  logic                                 aw_is_stat;
  logic                                 ar_is_ctrl;
  logic                                 ar_is_sel;
  logic                                 ar_is_stat;

  // ============================================================
  // axi4-lite write channels
  // each channel is taken on its own; the response waits for both
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign do_write      = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_full_reg <= 1'b0;
    end
  end

  // ============================================================
  // write decode
  // word aligned compare; low address bits are ignored
  assign aw_is_ctrl = aw_addr_reg[7:2] == tpc_pkg::TPC_CTRL_OFS[7:2];
  assign aw_is_sel  = aw_addr_reg[7:2] == tpc_pkg::TPC_SEL_OFS[7:2];
  assign aw_is_stat = aw_addr_reg[7:2] == tpc_pkg::TPC_STAT_OFS[7:2];
  // status is read only: a write there is answered okay and dropped
  assign wr_ctrl    = do_write && aw_is_ctrl;
  assign wr_sel     = do_write && aw_is_sel;
  assign wr_hit     = aw_is_ctrl || aw_is_sel || aw_is_stat;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= tpc_pkg::TPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? tpc_pkg::TPC_RESP_OKAY : tpc_pkg::TPC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ============================================================
  // control register
  always_comb
  begin
    ctrl_next = ctrl_reg;
    // RULE14: self clearing without hold
    // RULE12: hold keeps written values
    if (!ctrl_reg.hold)
    begin
      ctrl_next.shared_reset = 1'b0;
      ctrl_next.other_reset  = 1'b0;
    end
    if (wr_ctrl && w_strb_reg[0])
    begin
      ctrl_next.hold         = w_data_reg[tpc_pkg::TPC_HOLD_BIT];
      ctrl_next.other_reset  = w_data_reg[tpc_pkg::TPC_OTHER_BIT];
      ctrl_next.shared_reset = w_data_reg[tpc_pkg::TPC_SHARED_BIT];
    end
  end

  // RULE13: hold dropped clears resets
  // a write of hold zero leaves at most one reset cycle, then both clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg.hold         <= tpc_pkg::TPC_CTRL_RESET[tpc_pkg::TPC_HOLD_BIT];
      ctrl_reg.other_reset  <= tpc_pkg::TPC_CTRL_RESET[tpc_pkg::TPC_OTHER_BIT];
      ctrl_reg.shared_reset <= tpc_pkg::TPC_CTRL_RESET[tpc_pkg::TPC_SHARED_BIT];
    end
    else
      ctrl_reg <= ctrl_next;
  end

  assign shared_prescaler_reset = ctrl_reg.shared_reset;
  assign other_prescaler_reset  = ctrl_reg.other_reset;

  // ============================================================
  // clock select register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sel_reg <= tpc_pkg::TPC_SEL_RESET[SELS_W-1:0];
    else if (wr_sel)
    begin
      if (w_strb_reg[0])
        sel_reg[7:0] <= w_data_reg[7:0];
      if (w_strb_reg[1])
        sel_reg[SELS_W-1:8] <= w_data_reg[SELS_W-1:8];
    end
  end

  // ============================================================
  // shared prescaler
  // RULE3: runs regardless of selection
  // RULE5: reset restarts all timers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_reg <= '0;
    else if (ctrl_reg.shared_reset)
      presc_reg <= '0;
    else
      presc_reg <= presc_reg + 1'b1;
  end

  // RULE2: four divided taps
  // RULE4: phase left unaligned
  // a tap pulses on the last count of its period
  genvar t;
  generate
    for (t = 0; t < tpc_pkg::TPC_NUM_TAPS; t++)
    begin : g_tap
      // sized to the counter so a wider prescaler still compares cleanly
      localparam logic [PRESC_W-1:0] TAP_MASK = PRESC_W'(tpc_pkg::TPC_TAP_MASK[t]);
      // gated so no tap fires while the prescaler is held
      assign taps[t] = !ctrl_reg.shared_reset && ((presc_reg & TAP_MASK) == TAP_MASK);
    end
  endgenerate

  // ============================================================
  // per timer pin logic and source selection
  genvar n;
  generate
    for (n = 0; n < NUM_TIMERS; n++)
    begin : g_timer
      logic [tpc_pkg::TPC_SEL_W-1:0] sel_field;

      // field of this timer; the spare bit above it is stored but unused
      assign sel_field = sel_reg[n*tpc_pkg::TPC_SEL_STRIDE +: tpc_pkg::TPC_SEL_W];

      // RULE8: pin edge to tick
      tpc_pin_edge tpc_pin_edge_i
      (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (external_count_pin[n]),
        .level   (pin_level[n]),
        .rise    (pin_rise[n]),
        .fall    (pin_fall[n])
      );

      tpc_tick_select tpc_tick_select_i
      (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .clock_source_select (sel_field),
        .taps                (taps),
        .ext_rise            (pin_rise[n]),
        .ext_fall            (pin_fall[n]),
        .timer_tick          (timer_tick[n])
      );
    end
  endgenerate

  // ============================================================
  // axi4-lite read channel
  // one read in flight; a new address waits for the data to leave
  assign s_axi_arready = !rvalid_reg;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  // ============================================================
  // read decode
  // the address is decoded on the take edge; no copy is kept
  assign ar_is_ctrl = s_axi_araddr[7:2] == tpc_pkg::TPC_CTRL_OFS[7:2];
  assign ar_is_sel  = s_axi_araddr[7:2] == tpc_pkg::TPC_SEL_OFS[7:2];
  assign ar_is_stat = s_axi_araddr[7:2] == tpc_pkg::TPC_STAT_OFS[7:2];

  always_comb
  begin
    rd_value = '0;
    rd_hit   = 1'b1;
    if (ar_is_ctrl)
    begin
      rd_value[tpc_pkg::TPC_HOLD_BIT]   = ctrl_reg.hold;
      rd_value[tpc_pkg::TPC_OTHER_BIT]  = ctrl_reg.other_reset;
      rd_value[tpc_pkg::TPC_SHARED_BIT] = ctrl_reg.shared_reset;
    end
    else if (ar_is_sel)
      rd_value[SELS_W-1:0] = sel_reg;
    else if (ar_is_stat)
    begin
      rd_value[PRESC_W-1:0] = presc_reg;
      rd_value[tpc_pkg::TPC_STAT_PIN_LSB +: NUM_TIMERS] = pin_level;
    end
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= tpc_pkg::TPC_RESP_OKAY;
      rdata_reg  <= '0;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? tpc_pkg::TPC_RESP_OKAY : tpc_pkg::TPC_RESP_SLVERR;
      rdata_reg  <= rd_value;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

endmodule : tpc_prescaler_top
`default_nettype wire

// ===== tpc_prescaler_sva.sv
`default_nettype none
// ============================================================
// port checker of the prescaler front end
module tpc_prescaler_sva
#(
  parameter int NUM_TIMERS = tpc_pkg::TPC_NUM_TIMERS
)
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // register writes
  input wire logic [7:0]            s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  // timer side
  input wire logic [NUM_TIMERS-1:0] external_count_pin,
  input wire logic [NUM_TIMERS-1:0] timer_tick,
  input wire logic                  shared_prescaler_reset,
  input wire logic                  other_prescaler_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        take;
  logic [2:0]  sel_reg;
  logic        hold_reg;
  logic [11:0] calm_reg;
  logic [11:0] gap_reg;
  logic [11:0] div_n;

  // ============================================================
  // shadows; address and data are taken together by the bench
  assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sel_reg <= 3'h0;
    else if (take && s_axi_awaddr == tpc_pkg::TPC_SEL_OFS)
      sel_reg <= s_axi_wdata[2:0];

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      hold_reg <= 1'b0;
    else if (take && s_axi_awaddr == tpc_pkg::TPC_CTRL_OFS)
      hold_reg <= s_axi_wdata[7];

  // cycles since any write, saturating so long taps still count
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      calm_reg <= 12'h0;
    else if (take)
      calm_reg <= 12'h0;
    else if (calm_reg != 12'hfff)
      calm_reg <= calm_reg + 12'h1;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      gap_reg <= 12'h0;
    else if (timer_tick[0])
      gap_reg <= 12'h1;
    else if (gap_reg != 12'hfff)
      gap_reg <= gap_reg + 12'h1;

  always_comb
    case (sel_reg)
      3'h2: div_n = 12'd8;
      3'h3: div_n = 12'd64;
      3'h4: div_n = 12'd256;
      default: div_n = 12'd1024;
    endcase

  // ============================================================
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_SYS_TICK: assert property (sel_reg == 3'h1 && calm_reg > 12'd2 |-> timer_tick[0])
    else $error("no tick on system source");
  AST_OFF_QUIET: assert property (sel_reg == 3'h0 && calm_reg > 12'd5 |-> !timer_tick[0])
    else $error("tick while source off");
  AST_TAP_PERIOD: assert property (timer_tick[0] && sel_reg inside {[3'h2:3'h5]}
    && calm_reg > div_n + 12'd2 |-> gap_reg == div_n)
    else $error("wrong tap period");
  AST_SELF_CLEAR: assert property (shared_prescaler_reset && !hold_reg |=> !shared_prescaler_reset)
    else $error("reset bit not cleared");
  AST_HOLD_KEEP: assert property (shared_prescaler_reset && hold_reg && !take |=> shared_prescaler_reset)
    else $error("reset bit lost under hold");
  AST_HOLD_RELEASE: assert property ($fell(hold_reg) |=> !shared_prescaler_reset && !other_prescaler_reset)
    else $error("reset bits kept after hold release");
  AST_EXT_RISE: assert property (sel_reg == 3'h7 && calm_reg > 12'd3 && $rose(external_count_pin[0])
    |-> ##[2:4] timer_tick[0])
    else $error("rising pin edge missed");
  AST_EXT_FALL: assert property (sel_reg == 3'h6 && calm_reg > 12'd3 && $fell(external_count_pin[0])
    |-> ##[2:4] timer_tick[0])
    else $error("falling pin edge missed");
  AST_EXT_SINGLE: assert property (sel_reg == 3'h7 && calm_reg > 12'd3 && $fell(external_count_pin[0])
    |-> !timer_tick[0] [*4])
    else $error("tick on wrong pin edge");
endmodule : tpc_prescaler_sva

bind tpc_prescaler_top tpc_prescaler_sva #(.NUM_TIMERS(NUM_TIMERS)) tpc_prescaler_sva_i
(
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .external_count_pin(external_count_pin),
  .timer_tick(timer_tick),
  .shared_prescaler_reset(shared_prescaler_reset),
  .other_prescaler_reset(other_prescaler_reset)
);
`default_nettype wire

// ===== tpc_timer_model.sv
`default_nettype none
// ============================================================
// far side: count pin source and tick counting timers
module tpc_timer_model
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  input  wire logic       clr,
  output logic            busy,
  output logic [15:0]     cnt [3],
  // device side
  input  wire logic [2:0] timer_tick,
  output logic [2:0]      external_count_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] left_reg;
  logic [2:0] phase_reg;

  assign busy = left_reg != 9'h0;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      left_reg <= 9'h0;
    else if (go)
      left_reg <= {pulses, 1'b0};
    else if (busy && phase_reg == 3'h5)
      left_reg <= left_reg - 9'h1;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      phase_reg <= 3'h0;
    else if (go || phase_reg == 3'h5)
      phase_reg <= 3'h0;
    else
      phase_reg <= phase_reg + 3'h1;

  // pins idle low and move only inside a burst
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      external_count_pin <= 3'h0;
    else if (busy && phase_reg == 3'h5)
      external_count_pin <= ~external_count_pin;

  // one count per tick, as a timer would
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      cnt <= '{default: 16'h0};
    else
      for (int i = 0; i < 3; i++)
        if (clr)
          cnt[i] <= 16'h0;
        else if (timer_tick[i])
          cnt[i] <= cnt[i] + 16'h1;
endmodule : tpc_timer_model
`default_nettype wire

// ===== tpc_prescaler_top_test.sv
`default_nettype none
// ============================================================
// register and tick bench of the prescaler front end
module tpc_prescaler_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = tpc_pkg::TPC_CTRL_OFS;
  localparam logic [7:0] SL = tpc_pkg::TPC_SEL_OFS;
  localparam logic [1:0] OK = tpc_pkg::TPC_RESP_OKAY;
  localparam logic [1:0] ER = tpc_pkg::TPC_RESP_SLVERR;
  localparam int         DIVS [4] = '{8, 64, 256, 1024};
  logic        ref_clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic        sres, ores, go, clr, busy;
  logic [7:0]  awa, ara, pnum;
  logic [31:0] wd, rdt;
  logic [3:0]  strb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  pin, tick;
  logic [15:0] cnt [3];
  int          fail_count, n_tests, n;

  tpc_prescaler_top tpc_prescaler_top_i
  (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .external_count_pin(pin), .timer_tick(tick),
    .shared_prescaler_reset(sres), .other_prescaler_reset(ores)
  );

  tpc_timer_model tpc_timer_model_i
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .pulses(pnum), .clr(clr),
    .busy(busy), .cnt(cnt), .timer_tick(tick), .external_count_pin(pin)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // a wait that ran out ends the run
  task automatic hang(input logic ok);
    if (!ok)
    begin
      fail_count++;
      end_sim();
    end
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    int k;
    k = 0;
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      ah = awv && awr;
      wh = wv && wrd;
      bh = bv && br;
      if (bh)
        check({30'h0, bresp}, {30'h0, er});
      @(posedge ref_clk);
      if (ah)
        awv <= 1'b0;
      if (wh)
        wv <= 1'b0;
      if (bh)
        br <= 1'b0;
      k++;
    end while (!bh && k < 100);
    hang(bh);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh;
    int k;
    k = 0;
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      ah = arv && arr;
      rh = rv && rr;
      if (rh)
        check(rdt, ed);
      if (rh)
        check({30'h0, rresp}, {30'h0, er});
      @(posedge ref_clk);
      if (ah)
        arv <= 1'b0;
      if (rh)
        rr <= 1'b0;
      k++;
    end while (!rh && k < 100);
    hang(rh);
  endtask : rd

  // clears the tick counts, then lets c edges count
  task automatic window(input int c);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (c) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : window

  initial
  begin
    {rst_n, awv, wv, br, arv, rr, go, clr} = '0;
    {awa, ara, pnum, wd} = '0;
    strb = 4'hf;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(CT, 32'h0, OK);
    rd(SL, 32'h0, OK);
    rd(8'h30, 32'h0, ER);
    wr(8'h30, 32'hff, ER);
    wr(CT, 32'h1, OK);
    rd(CT, 32'h0, OK);
    wr(SL, 32'h001, OK);
    window(20);
    check({16'h0, cnt[0]}, 32'd20);
    check({16'h0, cnt[1] | cnt[2]}, 32'h0);
    // timer1 on each tap, timer2 on system clock, timer3 off
    for (int k = 0; k < 4; k++)
    begin
      wr(SL, 32'h012 + 32'(k), OK);
      repeat (20) @(posedge ref_clk);
      window(2 * DIVS[k]);
      check({16'h0, cnt[0]}, 32'd2);
      check({16'h0, cnt[1]}, 32'(2 * DIVS[k]));
      check({16'h0, cnt[2]}, 32'h0);
    end
    // pins stay low while sources change; timer1 sees rising, then falling edges
    for (int m = 0; m < 2; m++)
    begin
      wr(SL, (m == 0) ? 32'h767 : 32'h676, OK);
      window(10);
      pnum <= 8'd5;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      do @(negedge ref_clk); while (busy && ++n < 300);
      hang(!busy);
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int k = 0; k < 3; k++)
        check({16'h0, cnt[k]}, 32'd5);
    end
    wr(CT, 32'h83, OK);
    wr(SL, 32'h022, OK);
    window(30);
    check({16'h0, cnt[0] | cnt[1]}, 32'h0);
    check({30'h0, ores, sres}, 32'h3);
    rd(CT, 32'h83, OK);
    rd(tpc_pkg::TPC_STAT_OFS, 32'h0, OK);
    wr(CT, 32'h0, OK);
    n = 0;
    do @(negedge ref_clk); while (!tick[0] && ++n < 20);
    check({31'h0, tick[1]}, 32'h1);
    check(32'(n < 9), 32'h1);
    check({30'h0, ores, sres}, 32'h0);
    rd(CT, 32'h0, OK);
    end_sim();
  end
endmodule : tpc_prescaler_top_test
`default_nettype wire
